// ### tcsc_regs.vh
// Register offsets, field positions, reset values and timing counts of the camera status bank
`ifndef TCSC_REGS_VH
`define TCSC_REGS_VH
// =====================================================
// Register indexes (byte address = index * 4)
`define TCSC_IDX_BOARD_HEAT 8'h1c
`define TCSC_IDX_LINCORR_GAIN 8'h1d
`define TCSC_IDX_LINCORR_SHIFT 8'h1e
`define TCSC_IDX_INTERFRAME 8'h1f
`define TCSC_IDX_TARGET_RANGE 8'h20
`define TCSC_IDX_CALIB_PROGRESS 8'h21
`define TCSC_IDX_OP_KEY 8'h22
`define TCSC_IDX_LED_LIMIT 8'h24
`define TCSC_IDX_FOV_H 8'h26
`define TCSC_IDX_FOV_V 8'h27
`define TCSC_IDX_CAPTURE_DELAY 8'h2b
`define TCSC_IDX_BOOT_INFO 8'h2c
`define TCSC_IDX_ILLUM_C 8'h2d
`define TCSC_IDX_APP_FW 8'h2e
`define TCSC_IDX_RANGE_GAIN 8'h2f
`define TCSC_IDX_IRQ_STATUS 8'h60
`define TCSC_IDX_IRQ_MASK 8'h61
// =====================================================
// Reset values
`define TCSC_RST_ZERO 16'h0000
`define TCSC_RST_LED_LIMIT 16'h2328
`define TCSC_RST_BOOT_INFO 16'h4000
`define TCSC_RST_RANGE_GAIN 16'h4000
`define TCSC_SENSOR_ABSENT 16'hffff
// =====================================================
// Keys
`define TCSC_KEY_FLASH 16'h4877
`define TCSC_KEY_TEST 16'h5e6b
// =====================================================
// Calibration status fields and codes
`define TCSC_CAL_ERR_BIT 10
`define TCSC_CAL_NOFPN_BIT 12
`define TCSC_CAL_NOLENS_BIT 13
`define TCSC_CAL_TCOMP_BIT 14
`define TCSC_CAL_IDLE 8'h00
`define TCSC_CAL_DONE 8'ha1
`define TCSC_CAL_GENERIC_ERR 8'hff
`define TCSC_CAL_ERR_MIN 8'hf6
// =====================================================
// Boot counter field
`define TCSC_BOOT_CNT_LSB 14
// =====================================================
// Timing: 1 ms and 0.1 ms at 25 MHz
`define TCSC_CLK_HZ 25000000
`define TCSC_MS_NS 1000000
`define TCSC_TICK_MS_CYC (`TCSC_CLK_HZ / 1000)
`define TCSC_TICK_100US_CYC (`TCSC_CLK_HZ / 10000)
// =====================================================
// Interrupt status bits
`define TCSC_IRQ_CAL_DONE 0
`define TCSC_IRQ_CAL_ERR 1
`define TCSC_IRQ_CAPTURE 2
`define TCSC_IRQ_KEY 3
`define TCSC_IRQ_W 4
`endif

// ### tcsc_regbank.v
// AXI4-Lite register bank for depth camera status and configuration
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "tcsc_regs.vh"

// Function
// - Board temperature read-only in 0.01 C, all ones when sensor absent.
// - Linearization gain and shift are read/write, reset zero, value x 10000.
// - Interval between last two frames read-only, in 0.1 ms units.
// - Calibration target range in mm, read/write, reset zero.
// - Calibration status low byte reports progress codes 0..20 and 161.
// - Calibration status low byte reports failure codes 246..255.
// - Calibration status bits 10, 12, 13, 14 flag error and missing data.
// - Key register: 0x4877 enables flash ops, 0x5e6b enables tests, reset zero.
// - LED temperature limit read/write in 0.01 C, reset 0x2328.
// - Horizontal and vertical field of view read-only, 0.01 degree.
// - Capture waits programmed milliseconds after any trigger; reset zero.
// - In bootloader mode application version shows flashed application info.
// - Range gain is Q14 fixed point, reset 0x4000 meaning unity.
// - Illumination factor c is cubic linear term scaled by 1/1000.
// - Flash operations require flash key written first.
module tcsc_regbank (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire [9:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [9:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Live readings from the camera core
   input wire [15:0] board_heat_in,
   input wire board_sensor_present,
   input wire frame_mark,
   input wire [15:0] fov_h_in,
   input wire [15:0] fov_v_in,
   input wire [15:0] flashed_app_info,
   input wire [15:0] running_fw_info,
   input wire bootloader_mode,
   // Calibration engine status
   input wire [7:0] cal_code_in,
   input wire cal_no_fpn,
   input wire cal_no_lens,
   input wire cal_tcomp_err,
   // Boot attempt counter
   input wire boot_attempt,
   input wire boot_count_clear,
   // Trigger and capture
   input wire sw_trigger,
   input wire hw_trigger,
   output reg capture_start,
   // Configuration outputs
   output reg [15:0] lincorr_gain,
   output reg [15:0] lincorr_shift,
   output reg [15:0] target_range_mm,
   output reg [15:0] led_heat_limit,
   output reg [15:0] illum_comp_c,
   output reg [15:0] range_gain_q14,
   output reg flash_ops_enabled,
   output reg test_cmds_enabled,
   // Interrupt
   output reg irq
);

   // =====================================================
   // Pin synchronisers
   reg [15:0] heat_s1_q, heat_s2_q, heat_s3_q, heat_q;
   reg pres_s1_q, pres_s2_q;
   reg [1:0] trig_s1_q, trig_s2_q, trig_s3_q;
   reg frame_s1_q, frame_s2_q, frame_s3_q;
   always @(posedge aclk) begin
      if (!aresetn) begin
         heat_s1_q <= 16'h0000;
         heat_s2_q <= 16'h0000;
         heat_s3_q <= 16'h0000;
         heat_q <= 16'h0000;
         pres_s1_q <= 1'b0;
         pres_s2_q <= 1'b0;
         trig_s1_q <= 2'h0;
         trig_s2_q <= 2'h0;
         trig_s3_q <= 2'h0;
         frame_s1_q <= 1'b0;
         frame_s2_q <= 1'b0;
         frame_s3_q <= 1'b0;
      end else begin
         heat_s1_q <= board_heat_in;
         heat_s2_q <= heat_s1_q;
         heat_s3_q <= heat_s2_q;
         // A word seen twice alike is whole, not torn mid-change
         if (heat_s2_q == heat_s3_q)
            heat_q <= heat_s3_q;
         pres_s1_q <= board_sensor_present;
         pres_s2_q <= pres_s1_q;
         trig_s1_q <= {hw_trigger, sw_trigger};
         trig_s2_q <= trig_s1_q;
         trig_s3_q <= trig_s2_q;
         frame_s1_q <= frame_mark;
         frame_s2_q <= frame_s1_q;
         frame_s3_q <= frame_s2_q;
      end
   end
   wire trig_rise = |(trig_s2_q & ~trig_s3_q);
   wire frame_rise = frame_s2_q & ~frame_s3_q;

   // =====================================================
   // Registers
   reg [15:0] key_q;
   reg [15:0] capture_delay_q;
   reg [15:0] interval_q, interval_cnt_q;
   reg [1:0] boot_cnt_q;
   localparam [15:0] boot_rst_val = `TCSC_RST_BOOT_INFO;
   reg [15:0] cal_q;
   reg [`TCSC_IRQ_W-1:0] irq_stat_q, irq_mask_q;

   // Write channel: address and data latched independently
   reg [7:0] waddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg aw_have_q, w_have_q;
   wire wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
   wire wr_lo = wstrb_q[0];
   wire wr_hi = wstrb_q[1];
   wire [15:0] wr_val;
   reg wr_mapped;

   always @* begin
      case (waddr_q)
         `TCSC_IDX_BOARD_HEAT, `TCSC_IDX_LINCORR_GAIN, `TCSC_IDX_LINCORR_SHIFT,
         `TCSC_IDX_INTERFRAME, `TCSC_IDX_TARGET_RANGE, `TCSC_IDX_CALIB_PROGRESS,
         `TCSC_IDX_OP_KEY, `TCSC_IDX_LED_LIMIT, `TCSC_IDX_FOV_H, `TCSC_IDX_FOV_V,
         `TCSC_IDX_CAPTURE_DELAY, `TCSC_IDX_BOOT_INFO, `TCSC_IDX_ILLUM_C,
         `TCSC_IDX_APP_FW, `TCSC_IDX_RANGE_GAIN, `TCSC_IDX_IRQ_STATUS,
         `TCSC_IDX_IRQ_MASK: wr_mapped = 1'b1;
         default: wr_mapped = 1'b0;
      endcase
   end

   // Merge byte lanes into the old value of a 16-bit register
   function [15:0] merge;
      input [15:0] old;
      input [31:0] nw;
      input lo;
      input hi;
      begin
         merge = {hi ? nw[15:8] : old[15:8], lo ? nw[7:0] : old[7:0]};
      end
   endfunction
   assign wr_val = wdata_q[15:0];

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         waddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
      end else begin
         s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_have_q <= 1'b1;
            waddr_q <= s_axi_awaddr[9:2];
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? 2'b00 : 2'b10;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // =====================================================
   // Writable registers
   always @(posedge aclk) begin
      if (!aresetn) begin
         lincorr_gain <= `TCSC_RST_ZERO;
         lincorr_shift <= `TCSC_RST_ZERO;
         target_range_mm <= `TCSC_RST_ZERO;
         key_q <= `TCSC_RST_ZERO;
         led_heat_limit <= `TCSC_RST_LED_LIMIT;
         capture_delay_q <= `TCSC_RST_ZERO;
         illum_comp_c <= `TCSC_RST_ZERO;
         range_gain_q14 <= `TCSC_RST_RANGE_GAIN;
         irq_mask_q <= {`TCSC_IRQ_W{1'b0}};
      end else if (wr_fire) begin
         // Read-only indexes have no branch, so writes there fall away
         case (waddr_q)
            `TCSC_IDX_LINCORR_GAIN: lincorr_gain <= merge(lincorr_gain, wdata_q, wr_lo, wr_hi);
            `TCSC_IDX_LINCORR_SHIFT: lincorr_shift <= merge(lincorr_shift, wdata_q, wr_lo, wr_hi);
            `TCSC_IDX_TARGET_RANGE: target_range_mm <= merge(target_range_mm, wdata_q, wr_lo, wr_hi);
            `TCSC_IDX_OP_KEY: key_q <= merge(key_q, wdata_q, wr_lo, wr_hi);
            `TCSC_IDX_LED_LIMIT: led_heat_limit <= merge(led_heat_limit, wdata_q, wr_lo, wr_hi);
            `TCSC_IDX_CAPTURE_DELAY: capture_delay_q <= merge(capture_delay_q, wdata_q, wr_lo, wr_hi);
            `TCSC_IDX_ILLUM_C: illum_comp_c <= merge(illum_comp_c, wdata_q, wr_lo, wr_hi);
            `TCSC_IDX_RANGE_GAIN: range_gain_q14 <= merge(range_gain_q14, wdata_q, wr_lo, wr_hi);
            `TCSC_IDX_IRQ_MASK: if (wr_lo) irq_mask_q <= wr_val[`TCSC_IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // Key decode: exact values only, anything else disables both
   always @(posedge aclk) begin
      if (!aresetn) begin
         flash_ops_enabled <= 1'b0;
         test_cmds_enabled <= 1'b0;
      end else begin
         flash_ops_enabled <= (key_q == `TCSC_KEY_FLASH);
         test_cmds_enabled <= (key_q == `TCSC_KEY_TEST);
      end
   end

   // =====================================================
   // Frame interval in 0.1 ms; saturates rather than wrapping
   reg [15:0] tick100_q;
   wire tick100 = (tick100_q == `TCSC_TICK_100US_CYC - 1);
   always @(posedge aclk) begin
      if (!aresetn) begin
         tick100_q <= 16'h0000;
         interval_cnt_q <= 16'h0000;
         interval_q <= 16'h0000;
      end else begin
         tick100_q <= (tick100 | frame_rise) ? 16'h0000 : tick100_q + 16'h0001;
         if (frame_rise) begin
            interval_q <= interval_cnt_q;
            interval_cnt_q <= 16'h0000;
         end else if (tick100 && interval_cnt_q != 16'hffff) begin
            interval_cnt_q <= interval_cnt_q + 16'h0001;
         end
      end
   end

   // =====================================================
   // Trigger delay: a trigger during a pending delay restarts it
   reg [15:0] ms_tick_q;
   reg [15:0] delay_left_q;
   reg delay_busy_q;
   wire ms_tick = (ms_tick_q == `TCSC_TICK_MS_CYC - 1);
   always @(posedge aclk) begin
      if (!aresetn) begin
         ms_tick_q <= 16'h0000;
         delay_left_q <= 16'h0000;
         delay_busy_q <= 1'b0;
         capture_start <= 1'b0;
      end else begin
         capture_start <= 1'b0;
         ms_tick_q <= (ms_tick | trig_rise) ? 16'h0000 : ms_tick_q + 16'h0001;
         if (trig_rise) begin
            if (capture_delay_q == 16'h0000) begin
               capture_start <= 1'b1;
               delay_busy_q <= 1'b0;
            end else begin
               delay_left_q <= capture_delay_q;
               delay_busy_q <= 1'b1;
            end
         end else if (delay_busy_q && ms_tick) begin
            if (delay_left_q == 16'h0001) begin
               capture_start <= 1'b1;
               delay_busy_q <= 1'b0;
            end
            delay_left_q <= delay_left_q - 16'h0001;
         end
      end
   end

   // =====================================================
   // Calibration status and boot counter
   wire cal_is_err = (cal_code_in >= `TCSC_CAL_ERR_MIN);
   always @(posedge aclk) begin
      if (!aresetn) begin
         cal_q <= `TCSC_RST_ZERO;
         boot_cnt_q <= boot_rst_val[`TCSC_BOOT_CNT_LSB+1:`TCSC_BOOT_CNT_LSB];
      end else begin
         cal_q[7:0] <= cal_code_in;
         cal_q[`TCSC_CAL_ERR_BIT] <= cal_is_err;
         cal_q[`TCSC_CAL_NOFPN_BIT] <= cal_no_fpn;
         cal_q[`TCSC_CAL_NOLENS_BIT] <= cal_no_lens;
         cal_q[`TCSC_CAL_TCOMP_BIT] <= cal_tcomp_err;
         if (boot_count_clear)
            boot_cnt_q <= 2'b00;
         else if (boot_attempt && boot_cnt_q != 2'b11)
            boot_cnt_q <= boot_cnt_q + 2'b01;
      end
   end

   // =====================================================
   // Interrupts: set wins over write-one-to-clear
   reg [7:0] cal_prev_q;
   wire [`TCSC_IRQ_W-1:0] irq_set;
   assign irq_set[`TCSC_IRQ_CAL_DONE] = (cal_q[7:0] == `TCSC_CAL_DONE) &&
                                        (cal_prev_q != `TCSC_CAL_DONE);
   assign irq_set[`TCSC_IRQ_CAL_ERR] = cal_q[`TCSC_CAL_ERR_BIT] && (cal_prev_q < `TCSC_CAL_ERR_MIN);
   assign irq_set[`TCSC_IRQ_CAPTURE] = capture_start;
   assign irq_set[`TCSC_IRQ_KEY] = wr_fire && (waddr_q == `TCSC_IDX_OP_KEY);
   wire irq_clr = wr_fire && (waddr_q == `TCSC_IDX_IRQ_STATUS) && wr_lo;
   always @(posedge aclk) begin
      if (!aresetn) begin
         cal_prev_q <= `TCSC_CAL_IDLE;
         irq_stat_q <= {`TCSC_IRQ_W{1'b0}};
         irq <= 1'b0;
      end else begin
         cal_prev_q <= cal_q[7:0];
         irq_stat_q <= (irq_stat_q & ~(irq_clr ? wr_val[`TCSC_IRQ_W-1:0] : {`TCSC_IRQ_W{1'b0}}))
                       | irq_set;
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   // =====================================================
   // Read channel: one-cycle decode, SLVERR on unmapped
   reg [15:0] rd_val;
   reg rd_ok;
   wire [7:0] raddr = s_axi_araddr[9:2];
   always @* begin
      rd_ok = 1'b1;
      case (raddr)
         `TCSC_IDX_BOARD_HEAT: rd_val = pres_s2_q ? heat_q : `TCSC_SENSOR_ABSENT;
         `TCSC_IDX_LINCORR_GAIN: rd_val = lincorr_gain;
         `TCSC_IDX_LINCORR_SHIFT: rd_val = lincorr_shift;
         `TCSC_IDX_INTERFRAME: rd_val = interval_q;
         `TCSC_IDX_TARGET_RANGE: rd_val = target_range_mm;
         `TCSC_IDX_CALIB_PROGRESS: rd_val = cal_q;
         `TCSC_IDX_OP_KEY: rd_val = key_q;
         `TCSC_IDX_LED_LIMIT: rd_val = led_heat_limit;
         `TCSC_IDX_FOV_H: rd_val = fov_h_in;
         `TCSC_IDX_FOV_V: rd_val = fov_v_in;
         `TCSC_IDX_CAPTURE_DELAY: rd_val = capture_delay_q;
         `TCSC_IDX_BOOT_INFO: rd_val = {boot_cnt_q, 14'h0000};
         `TCSC_IDX_ILLUM_C: rd_val = illum_comp_c;
         `TCSC_IDX_APP_FW: rd_val = bootloader_mode ? flashed_app_info : running_fw_info;
         `TCSC_IDX_RANGE_GAIN: rd_val = range_gain_q14;
         `TCSC_IDX_IRQ_STATUS: rd_val = {12'h000, irq_stat_q};
         `TCSC_IDX_IRQ_MASK: rd_val = {12'h000, irq_mask_q};
         default: begin
            rd_val = 16'h0000;
            rd_ok = 1'b0;
         end
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, rd_val};
            s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// ### tcsc_regbank_chk.sv
// Concurrent checker on the ports of the camera status register bank
`timescale 1ns/1ns
`default_nettype none
module tcsc_regbank_chk (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes
   input wire logic s_axi_awready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Block outputs
   input wire logic capture_start,
   input wire logic flash_ops_enabled,
   input wire logic test_cmds_enabled,
   input wire logic [15:0] lincorr_gain,
   input wire logic [15:0] led_heat_limit,
   input wire logic [15:0] range_gain_q14
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========================================
   // Bus channel behaviour
   property p_bvalid_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped early");
   property p_rvalid_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped early");
   property p_awready_pulse;
      s_axi_awready |=> !s_axi_awready;
   endproperty
   a_awready_pulse: assert property (p_awready_pulse) else $error("awready longer than a pulse");
   property p_rvalid_follows;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rvalid_follows: assert property (p_rvalid_follows) else $error("read answer late");
   // ==========================================
   // Register contents, key enables and capture pulse
   property p_rdata_upper;
      s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
   endproperty
   a_rdata_upper: assert property (p_rdata_upper) else $error("upper read half not zero");
   property p_reset_vals;
      $rose(aresetn) |-> led_heat_limit == 16'h2328 && range_gain_q14 == 16'h4000
         && lincorr_gain == 16'h0000;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("bad value after reset");
   property p_keys_apart;
      flash_ops_enabled |-> !test_cmds_enabled;
   endproperty
   a_keys_apart: assert property (p_keys_apart) else $error("both key enables high");
   property p_capture_pulse;
      capture_start |=> !capture_start;
   endproperty
   a_capture_pulse: assert property (p_capture_pulse) else $error("capture pulse too long");
endmodule
bind tcsc_regbank tcsc_regbank_chk tcsc_regbank_chk_inst (.aclk, .aresetn, .s_axi_awready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .capture_start, .flash_ops_enabled, .test_cmds_enabled,
   .lincorr_gain, .led_heat_limit, .range_gain_q14);
`default_nettype wire

// ### tof_camera_status_config_regs_test.sv
// Self-checking bench for the camera status register bank
`timescale 1ns/1ns
`default_nettype none
module tof_camera_status_config_regs_test;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [9:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, lf;
   logic [3:0] s_axi_wstrb;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire capture_start, flash_ops_enabled, test_cmds_enabled, irq;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [15:0] lincorr_gain, lincorr_shift, target_range_mm, led_heat_limit, illum_comp_c;
   wire [15:0] range_gain_q14;
   logic [15:0] board_heat_in, fov_h_in, fov_v_in, flashed_app_info, running_fw_info, v;
   logic [7:0] cal_code_in;
   logic board_sensor_present, frame_mark, bootloader_mode, cal_no_fpn, cal_no_lens;
   logic cal_tcomp_err, boot_attempt, boot_count_clear, sw_trigger, hw_trigger;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   logic [15:0] wv[7];
   logic [7:0] wi[7] = '{8'h1d, 8'h1e, 8'h20, 8'h24, 8'h2b, 8'h2d, 8'h2f};
   logic [7:0] di[9] = '{8'h1d, 8'h1e, 8'h20, 8'h22, 8'h24, 8'h2b, 8'h2c, 8'h2d, 8'h2f};
   logic [15:0] dv[9] = '{0, 0, 0, 0, 16'h2328, 0, 16'h4000, 0, 16'h4000};
   logic [7:0] ri[7] = '{8'h1c, 8'h1f, 8'h21, 8'h26, 8'h27, 8'h2c, 8'h2e};
   logic [7:0] cc[17] = '{0, 2, 3, 4, 5, 6, 17, 18, 19, 20, 161, 255, 254, 252, 249, 248, 246};
   int fail_count, total_checks, n;
   tcsc_regbank tcsc_regbank_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .board_heat_in,
      .board_sensor_present, .frame_mark, .fov_h_in, .fov_v_in, .flashed_app_info,
      .running_fw_info, .bootloader_mode, .cal_code_in, .cal_no_fpn, .cal_no_lens,
      .cal_tcomp_err, .boot_attempt, .boot_count_clear, .sw_trigger, .hw_trigger,
      .capture_start, .lincorr_gain, .lincorr_shift, .target_range_mm, .led_heat_limit,
      .illum_comp_c, .range_gain_q14, .flash_ops_enabled, .test_cmds_enabled, .irq);
   initial begin
      aclk = 0;
      forever #20 aclk = ~aclk;
   end
   // ==========================================
   // Compare tasks and result monitor
   task automatic note(input logic [33:0] g, input logic [33:0] e);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic cmp_rd(input logic [33:0] g, input logic [33:0] e); note(g, e); endtask
   task automatic cmp_wr(input logic [1:0] g, input logic [1:0] e); note({32'h0, g}, {32'h0, e});
   endtask
   task automatic cmp_out(input logic [15:0] g, input logic [15:0] e);
      note({18'h0, g}, {18'h0, e});
   endtask
   always @(posedge aclk) begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) cmp_rd({s_axi_rresp, s_axi_rdata},
         rq.pop_front());
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
         cmp_wr(s_axi_bresp, bq.pop_front());
   end
   // ==========================================
   // Stimulus helpers
   function automatic logic [15:0] nxt();
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return lf[15:0];
   endfunction
   task automatic wr(input logic [7:0] idx, input logic [15:0] d, input logic [1:0] e);
      logic a, w;
      a = 0;
      w = 0;
      bq.push_back(e);
      @(posedge aclk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {lf[31:16], d};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (!(a && w)) begin
         @(negedge aclk);
         a = a | (s_axi_awready === 1'b1);
         w = w | (s_axi_wready === 1'b1);
         @(posedge aclk);
         if (a) s_axi_awvalid <= 0;
         if (w) s_axi_wvalid <= 0;
      end
      do begin @(negedge aclk); a = s_axi_bvalid === 1'b1; @(posedge aclk); end while (!a);
      s_axi_bready <= 0;
   endtask
   task automatic rd(input logic [7:0] idx, input logic [15:0] d, input logic [1:0] e);
      logic a;
      rq.push_back({e, 16'h0, d});
      @(posedge aclk);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin @(negedge aclk); a = s_axi_arready === 1'b1; @(posedge aclk); end while (!a);
      s_axi_arvalid <= 0;
      do begin @(negedge aclk); a = s_axi_rvalid === 1'b1; @(posedge aclk); end while (!a);
      s_axi_rready <= 0;
   endtask
   task automatic bump(input logic clr);
      @(posedge aclk);
      if (clr) boot_count_clear <= 1; else boot_attempt <= 1;
      @(posedge aclk);
      boot_count_clear <= 0;
      boot_attempt <= 0;
   endtask
   // Counts cycles from trigger edge to capture pulse
   task automatic trig(input logic hw);
      @(posedge aclk);
      if (hw) hw_trigger <= 1; else sw_trigger <= 1;
      n = 0;
      do begin @(negedge aclk); n++; end while (capture_start !== 1'b1 && n < 30000);
      @(posedge aclk);
      sw_trigger <= 0;
      hw_trigger <= 0;
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #(40 * 60000);
      fail_count++;
      complete_run();
   end
   // ==========================================
   // Main sequence
   initial begin
      lf = 32'd85121;
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
      s_axi_wstrb = 4'h3;
      {frame_mark, bootloader_mode, boot_attempt, boot_count_clear, sw_trigger, hw_trigger} = 0;
      {cal_code_in, cal_no_fpn, cal_no_lens, cal_tcomp_err} = 0;
      board_sensor_present = 1;
      board_heat_in = nxt();
      fov_h_in = nxt();
      fov_v_in = nxt();
      flashed_app_info = nxt();
      running_fw_info = nxt();
      repeat (16) @(posedge aclk);
      aresetn <= 1;
      foreach (di[i]) rd(di[i], dv[i], 2'b00);
      foreach (wi[i]) begin
         wv[i] = nxt();
         wr(wi[i], wv[i], 2'b00);
         rd(wi[i], wv[i], 2'b00);
      end
      cmp_out(lincorr_gain, wv[0]);
      cmp_out(lincorr_shift, wv[1]);
      cmp_out(target_range_mm, wv[2]);
      cmp_out(led_heat_limit, wv[3]);
      cmp_out(illum_comp_c, wv[5]);
      cmp_out(range_gain_q14, wv[6]);
      foreach (ri[i]) wr(ri[i], nxt(), 2'b00);
      rd(8'h1c, board_heat_in, 2'b00);
      rd(8'h26, fov_h_in, 2'b00);
      rd(8'h27, fov_v_in, 2'b00);
      rd(8'h2e, running_fw_info, 2'b00);
      rd(8'h2c, 16'h4000, 2'b00);
      board_sensor_present <= 0;
      bootloader_mode <= 1;
      bump(0);
      rd(8'h1c, 16'hffff, 2'b00);
      rd(8'h2e, flashed_app_info, 2'b00);
      rd(8'h2c, 16'h8000, 2'b00);
      bump(0);
      bump(0);
      rd(8'h2c, 16'hc000, 2'b00);
      bump(1);
      rd(8'h2c, 16'h0000, 2'b00);
      foreach (cc[i]) begin
         v = nxt();
         @(posedge aclk);
         cal_code_in <= cc[i];
         {cal_tcomp_err, cal_no_lens, cal_no_fpn} <= v[2:0];
         rd(8'h21, {1'b0, v[2:0], 1'b0, cc[i] >= 8'hf6, 2'b00, cc[i]}, 2'b00);
      end
      rd(8'h60, 16'h0003, 2'b00);
      // Frame edges 7601 cycles apart hold three whole 0.1 ms ticks
      @(posedge aclk);
      frame_mark <= 1;
      repeat (7600) @(posedge aclk);
      frame_mark <= 0;
      @(posedge aclk);
      frame_mark <= 1;
      repeat (4) @(posedge aclk);
      rd(8'h1f, 16'h0003, 2'b00);
      wr(8'h22, 16'h4877, 2'b00);
      @(negedge aclk);
      cmp_out({flash_ops_enabled, test_cmds_enabled}, 16'h0002);
      rd(8'h22, 16'h4877, 2'b00);
      wr(8'h22, 16'h5e6b, 2'b00);
      @(negedge aclk);
      cmp_out({flash_ops_enabled, test_cmds_enabled}, 16'h0001);
      wr(8'h22, 16'h1234, 2'b00);
      @(negedge aclk);
      cmp_out({flash_ops_enabled, test_cmds_enabled}, 16'h0000);
      // Capture events with the capture bit unmasked, then masked
      wr(8'h61, 16'h0004, 2'b00);
      wr(8'h60, 16'h000f, 2'b00);
      wr(8'h2b, 16'h0000, 2'b00);
      trig(0);
      cmp_out(n >= 2 && n <= 8, 1);
      repeat (2) @(posedge aclk);
      cmp_out(irq, 1);
      rd(8'h60, 16'h0004, 2'b00);
      wr(8'h60, 16'h0004, 2'b00);
      repeat (2) @(posedge aclk);
      cmp_out(irq, 0);
      wr(8'h61, 16'h0000, 2'b00);
      wr(8'h2b, 16'h0001, 2'b00);
      trig(1);
      cmp_out(n >= 24990 && n <= 25010, 1);
      wr(8'h22, 16'h5e6b, 2'b00);
      rd(8'h60, 16'h000c, 2'b00);
      cmp_out(irq, 0);
      rd(8'h23, 16'h0000, 2'b10);
      wr(8'h23, nxt(), 2'b10);
      repeat (4) @(posedge aclk);
      complete_run();
   end
endmodule
`default_nettype wire
